// ---- qdb_pkg.sv ----
// qdb_pkg: constants and types shared by the serial flash host controller.
// assumes: included before any module of the controller; no clock or reset here.

package qdb_pkg;

   // ****************************************************************
   // flash opcodes
   // ****************************************************************
   localparam logic [7:0] OPC_QDDR_READ    = 8'hed;
   localparam logic [7:0] OPC_SECTOR_OPEN  = 8'h26;
   localparam logic [7:0] OPC_SECTOR_CLOSE = 8'h24;
   localparam logic [7:0] OPC_BOOT_RD      = 8'h14;
   localparam logic [7:0] OPC_BOOT_WR      = 8'h15;
   localparam logic [7:0] OPC_WRITE_ALLOW  = 8'h06;
   localparam logic [7:0] MODE_CONT        = 8'ha0;
   localparam logic [7:0] MODE_EXIT        = 8'h00;
   localparam logic [3:0] MODE_CONT_NIB    = 4'ha;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_CMD    = 8'h04;
   localparam logic [7:0] REG_ADDR   = 8'h08;
   localparam logic [7:0] REG_WDATA  = 8'h0c;
   localparam logic [7:0] REG_RDATA  = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;

   localparam int CTRL_QPI_BIT   = 0;
   localparam int CTRL_QLA_BIT   = 1;
   localparam int CTRL_CONT_BIT  = 2;
   localparam int CTRL_NB_LSB    = 4;
   localparam int CTRL_DUMMY_LSB = 8;
   localparam int CTRL_BWAIT_LSB = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0630;

   localparam int ST_BUSY_BIT     = 0;
   localparam int ST_ERR_BIT      = 1;
   localparam int ST_CONT_BIT     = 2;
   localparam int ST_OPEN_BIT     = 3;
   localparam int ST_BOOTDONE_BIT = 4;

   localparam int SECTOR_LSB = 12;
   localparam int ADDR_BITS  = 24;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int PCLK_MHZ     = 100;
   localparam int SCK_MAX_MHZ  = 133;
   // shortest legal half period in pclk cycles, rounded up, at least one
   localparam int SCK_HALF_MIN = (PCLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
   // four cycles leave room for the two-stage input synchroniser
   localparam int SCK_HALF_DEF = (SCK_HALF_MIN > 4) ? SCK_HALF_MIN : 4;
   localparam logic [5:0] CS_GAP_SLOTS = 6'h02;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      OP_QDDR_READ   = 3'h0,
      OP_SEC_OPEN    = 3'h1,
      OP_SEC_CLOSE   = 3'h2,
      OP_BOOT_STREAM = 3'h3,
      OP_WORD_RD     = 3'h4,
      OP_WORD_WR     = 3'h5
   } qdb_op_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CMD   = 3'b001,
      ST_ADDR  = 3'b011,
      ST_MODE  = 3'b010,
      ST_DUMMY = 3'b110,
      ST_WDATA = 3'b111,
      ST_RDATA = 3'b101,
      ST_GAP   = 3'b100
   } qdb_st_t;

endpackage

// ---- qdb_sync.sv ----
// qdb_sync: two-stage synchroniser for a bus of asynchronous levels.
// assumes: inputs come from pins; output is read only in the pclk domain.
`timescale 1ns/10ps
`default_nettype none

module qdb_sync #(
   parameter int W = 4
)(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule
`default_nettype wire

// ---- qdb_host.sv ----
// qdb_host: host controller for a quad serial flash, driven over APB.
// assumes: pclk 100 MHz, flash pins joined by the bench through a mux on flash_io_oe.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module qdb_host
   import qdb_pkg::*;
#(
   parameter int SCK_HALF = SCK_HALF_DEF
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             flash_sck,
   output logic             flash_cs_n,
   input  wire logic [3:0]  flash_io_in,
   output logic      [3:0]  flash_io_out,
   output logic      [3:0]  flash_io_oe
);

   localparam logic [3:0] PH_LAST = 4'(SCK_HALF - 1);
   localparam logic [3:0] PH_MID  = 4'(SCK_HALF / 2);

   // ****************************************************************
   // state
   // ****************************************************************
   qdb_st_t     st_ff, nxt_st, after, tgt, start_st;
   qdb_op_t     op_ff, nxt_op, op_e, cmd_op;
   logic [3:0]  ph_ff, nxt_ph;
   logic        sck_ff, nxt_sck, cs_n_ff, nxt_cs_n;
   logic [5:0]  slot_ff, nxt_slot, bytes;
   logic [31:0] tx_ff, nxt_tx;
   logic [7:0]  rxb_ff, nxt_rxb, newb;
   logic [3:0]  rxbits_ff, nxt_rxbits, step;
   logic [1:0]  bidx_ff, nxt_bidx;
   logic [31:0] rword_ff, nxt_rword;
   logic [3:0]  io_out_ff, nxt_io_out, io_oe_ff, nxt_io_oe;
   logic        pend_ff, nxt_pend, pend_e;
   logic        cont_ff, nxt_cont, open_ff, nxt_open;
   logic [11:0] sector_ff, nxt_sector;
   logic        boot_done_ff, nxt_boot_done, err_ff, nxt_err;
   logic [31:0] ctrl_ff, nxt_ctrl, addr_ff, nxt_addr, wdata_ff, nxt_wdata;
   logic [31:0] prdata_ff, nxt_prdata, stat;
   logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic [3:0]  io_s;
   logic [7:0]  opcode;
   logic        four_line_cmd_mode, qla, contreq, acc, setup, cmd_wr, op_ok, refuse;
   logic        last, framed, wide, ddr, out_st, active, drv, smp, dec, fin, do_enter;
   logic [3:0]  dmy, bwait;

   qdb_sync #(.W(4)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (flash_io_in),
      .q       (io_s)
   );

   assign four_line_cmd_mode     = ctrl_ff[CTRL_QPI_BIT];
   assign qla     = ctrl_ff[CTRL_QLA_BIT];
   assign contreq = ctrl_ff[CTRL_CONT_BIT];
   assign dmy     = ctrl_ff[CTRL_DUMMY_LSB +: 4];
   assign bwait   = ctrl_ff[CTRL_BWAIT_LSB +: 4];
   assign bytes   = {4'h0, ctrl_ff[CTRL_NB_LSB +: 2]} + 6'h01;

   // ****************************************************************
   // apb slave and sequencer
   // ****************************************************************
   always_comb begin
      nxt_st = st_ff;  nxt_op = op_ff;  nxt_ph = ph_ff;  nxt_sck = sck_ff;
      nxt_cs_n = cs_n_ff;  nxt_slot = slot_ff;  nxt_tx = tx_ff;
      nxt_rxb = rxb_ff;  nxt_rxbits = rxbits_ff;  nxt_bidx = bidx_ff;
      nxt_rword = rword_ff;  nxt_io_out = io_out_ff;  nxt_io_oe = io_oe_ff;
      nxt_pend = pend_ff;  nxt_cont = cont_ff;  nxt_open = open_ff;
      nxt_sector = sector_ff;  nxt_boot_done = boot_done_ff;  nxt_err = err_ff;
      nxt_ctrl = ctrl_ff;  nxt_addr = addr_ff;  nxt_wdata = wdata_ff;
      nxt_prdata = prdata_ff;  nxt_pslverr = pslverr_ff;
      do_enter = 1'b0;  tgt = ST_IDLE;  op_e = op_ff;  pend_e = pend_ff;
      newb = 8'h00;  step = 4'h1;  opcode = OPC_QDDR_READ;

      stat = 32'h0;
      stat[ST_BUSY_BIT]     = (st_ff != ST_IDLE);
      stat[ST_ERR_BIT]      = err_ff;
      stat[ST_CONT_BIT]     = cont_ff;
      stat[ST_OPEN_BIT]     = open_ff;
      stat[ST_BOOTDONE_BIT] = boot_done_ff;

      // answer after one wait state; writes commit at the edge with pready high
      setup      = psel && penable && !pready_ff;
      acc        = psel && penable && pready_ff;
      nxt_pready = setup;
      cmd_op     = qdb_op_t'(pwdata[2:0]);
      op_ok      = (pwdata[2:0] <= 3'h5);
      refuse     = ((cmd_op == OP_QDDR_READ) && !four_line_cmd_mode && !qla)
                || ((cmd_op == OP_SEC_OPEN) && open_ff
                    && (addr_ff[ADDR_BITS-1:SECTOR_LSB] != sector_ff))
                || ((cmd_op == OP_BOOT_STREAM) && boot_done_ff);
      if (setup) begin
         nxt_pslverr = 1'b0;
         nxt_prdata  = 32'h0;
         case (paddr)
            REG_CTRL:   nxt_prdata = ctrl_ff;
            REG_ADDR:   nxt_prdata = addr_ff;
            REG_WDATA:  nxt_prdata = wdata_ff;
            REG_RDATA:  nxt_prdata = rword_ff;
            REG_STATUS: nxt_prdata = stat;
            REG_CMD:    nxt_pslverr = pwrite && ((st_ff != ST_IDLE) || !op_ok);
            default:    nxt_pslverr = 1'b1;
         endcase
      end
      cmd_wr = acc && pwrite && (paddr == REG_CMD) && (st_ff == ST_IDLE) && op_ok;
      if (acc && pwrite) begin
         case (paddr)
            REG_CTRL:   nxt_ctrl = pwdata;
            REG_ADDR:   nxt_addr = pwdata;
            REG_WDATA:  nxt_wdata = pwdata;
            REG_STATUS: if (pwdata[ST_ERR_BIT]) nxt_err = 1'b0;
            default:    nxt_ctrl = ctrl_ff;
         endcase
      end

      // beat engine: one beat is half an sck period
      last   = (ph_ff == PH_LAST);
      framed = (st_ff != ST_IDLE) && (st_ff != ST_GAP);
      ddr    = (op_ff == OP_QDDR_READ)
            && ((st_ff == ST_ADDR) || (st_ff == ST_MODE) || (st_ff == ST_RDATA));
      case (st_ff)
         ST_CMD:   wide = four_line_cmd_mode;
         ST_ADDR:  wide = (op_ff == OP_QDDR_READ) || four_line_cmd_mode;
         ST_MODE:  wide = 1'b1;
         ST_WDATA: wide = four_line_cmd_mode;
         ST_RDATA: wide = (op_ff == OP_QDDR_READ) || ((op_ff == OP_BOOT_STREAM) ? qla : four_line_cmd_mode);
         default:  wide = 1'b0;
      endcase
      out_st = (st_ff == ST_CMD) || (st_ff == ST_ADDR) || (st_ff == ST_MODE) || (st_ff == ST_WDATA);
      active = ddr || !sck_ff;
      drv    = framed && out_st && active && (ph_ff == PH_MID);
      smp    = (st_ff == ST_RDATA) && active && last;
      dec    = ((st_ff == ST_GAP) && last) || (framed && last && (ddr || sck_ff));
      fin    = dec && (slot_ff == 6'h01);

      if (st_ff != ST_IDLE) begin
         nxt_ph = last ? 4'h0 : ph_ff + 4'h1;
         if (framed && last) nxt_sck = !sck_ff;
      end
      if (drv) begin
         nxt_io_out = wide ? tx_ff[31:28] : {3'h0, tx_ff[31]};
         nxt_io_oe  = wide ? 4'hf : 4'h1;
         nxt_tx     = wide ? {tx_ff[27:0], 4'h0} : {tx_ff[30:0], 1'b0};
         if ((st_ff == ST_MODE) && sck_ff && (dmy == 4'h1)) nxt_io_oe = 4'h0;
      end
      if (smp) begin
         step    = wide ? 4'h4 : 4'h1;
         newb    = wide ? {rxb_ff[3:0], io_s} : {rxb_ff[6:0], io_s[1]};
         nxt_rxb = newb;
         nxt_rxbits = rxbits_ff + step;
         if (rxbits_ff + step == 4'h8) begin
            // bytes pack low byte first, as the boot word arrives
            nxt_rword[bidx_ff*8 +: 8] = newb;
            nxt_bidx   = bidx_ff + 2'h1;
            nxt_rxbits = 4'h0;
         end
      end
      if (dec) nxt_slot = slot_ff - 6'h01;

      case (st_ff)
         ST_CMD:   after = ((op_ff == OP_SEC_CLOSE) || pend_ff) ? ST_GAP :
                           (op_ff == OP_WORD_RD) ? ST_RDATA :
                           (op_ff == OP_WORD_WR) ? ST_WDATA : ST_ADDR;
         ST_ADDR:  after = (op_ff == OP_QDDR_READ) ? ST_MODE : ST_GAP;
         ST_MODE:  after = (dmy > 4'h1) ? ST_DUMMY : ST_RDATA;
         ST_DUMMY: after = ST_RDATA;
         default:  after = ST_GAP;
      endcase

      if (fin) begin
         if ((st_ff == ST_ADDR) && (op_ff == OP_SEC_OPEN)) begin
            nxt_open   = 1'b1;
            nxt_sector = addr_ff[ADDR_BITS-1:SECTOR_LSB];
         end
         if ((st_ff == ST_CMD) && (op_ff == OP_SEC_CLOSE)) nxt_open = 1'b0;
         if (st_ff == ST_GAP) begin
            if (pend_ff) begin
               do_enter = 1'b1;
               tgt      = ST_CMD;
               nxt_pend = 1'b0;
               pend_e   = 1'b0;
            end else begin
               nxt_st = ST_IDLE;
            end
         end else begin
            do_enter = 1'b1;
            tgt      = after;
         end
      end

      case (cmd_op)
         OP_QDDR_READ:   start_st = cont_ff ? ST_ADDR : ST_CMD;
         OP_BOOT_STREAM: start_st = (bwait != 4'h0) ? ST_DUMMY : ST_RDATA;
         default:        start_st = ST_CMD;
      endcase
      if (cmd_wr) begin
         if (refuse) begin
            nxt_err = 1'b1;
         end else begin
            do_enter   = 1'b1;
            tgt        = start_st;
            op_e       = cmd_op;
            nxt_op     = cmd_op;
            pend_e     = (cmd_op == OP_WORD_WR);
            nxt_pend   = pend_e;
            nxt_rword  = 32'h0;
            nxt_rxbits = 4'h0;
            nxt_bidx   = 2'h0;
            nxt_ph     = 4'h0;
            nxt_sck    = 1'b0;
            if (cmd_op == OP_BOOT_STREAM) nxt_boot_done = 1'b1;
         end
      end

      // enter a phase: load its slot count and shift data
      case (op_e)
         OP_SEC_OPEN:  opcode = OPC_SECTOR_OPEN;
         OP_SEC_CLOSE: opcode = OPC_SECTOR_CLOSE;
         OP_WORD_RD:   opcode = OPC_BOOT_RD;
         OP_WORD_WR:   opcode = pend_e ? OPC_WRITE_ALLOW : OPC_BOOT_WR;
         default:      opcode = OPC_QDDR_READ;
      endcase
      if (do_enter) begin
         nxt_st   = tgt;
         nxt_cs_n = (tgt == ST_GAP);
         case (tgt)
            ST_CMD: begin
               nxt_slot = four_line_cmd_mode ? 6'd2 : 6'd8;
               nxt_tx   = {opcode, 24'h0};
            end
            ST_ADDR: begin
               nxt_slot = ((op_e == OP_QDDR_READ) || four_line_cmd_mode) ? 6'd6 : 6'd24;
               nxt_tx   = {addr_ff[ADDR_BITS-1:0], 8'h0};
            end
            ST_MODE: begin
               nxt_slot = 6'd2;
               nxt_tx   = {(contreq ? MODE_CONT : MODE_EXIT), 24'h0};
               nxt_cont = contreq;
            end
            ST_DUMMY: nxt_slot = (op_e == OP_BOOT_STREAM) ? {2'h0, bwait}
                                                          : {2'h0, dmy - 4'h1};
            ST_WDATA: begin
               nxt_slot = four_line_cmd_mode ? 6'd8 : 6'd32;
               nxt_tx   = {wdata_ff[7:0], wdata_ff[15:8], wdata_ff[23:16], wdata_ff[31:24]};
            end
            ST_RDATA: nxt_slot = (op_e == OP_QDDR_READ) ? (bytes << 1) :
                                 (op_e == OP_BOOT_STREAM) ? (qla ? (bytes << 1) : (bytes << 3)) :
                                 (four_line_cmd_mode ? 6'd8 : 6'd32);
            default:  nxt_slot = CS_GAP_SLOTS;
         endcase
         if ((tgt == ST_DUMMY) || (tgt == ST_RDATA) || (tgt == ST_GAP)) nxt_io_oe = 4'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ST_IDLE;  op_ff <= OP_QDDR_READ;  ph_ff <= 4'h0;  sck_ff <= 1'b0;
         cs_n_ff <= 1'b1;  slot_ff <= 6'h00;  tx_ff <= 32'h0;  rxb_ff <= 8'h00;
         rxbits_ff <= 4'h0;  bidx_ff <= 2'h0;  rword_ff <= 32'h0;
         io_out_ff <= 4'h0;  io_oe_ff <= 4'h0;  pend_ff <= 1'b0;  cont_ff <= 1'b0;
         open_ff <= 1'b0;  sector_ff <= 12'h000;  boot_done_ff <= 1'b0;  err_ff <= 1'b0;
         ctrl_ff <= CTRL_RESET;  addr_ff <= 32'h0;  wdata_ff <= 32'h0;
         prdata_ff <= 32'h0;  pready_ff <= 1'b0;  pslverr_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;  op_ff <= nxt_op;  ph_ff <= nxt_ph;  sck_ff <= nxt_sck;
         cs_n_ff <= nxt_cs_n;  slot_ff <= nxt_slot;  tx_ff <= nxt_tx;  rxb_ff <= nxt_rxb;
         rxbits_ff <= nxt_rxbits;  bidx_ff <= nxt_bidx;  rword_ff <= nxt_rword;
         io_out_ff <= nxt_io_out;  io_oe_ff <= nxt_io_oe;  pend_ff <= nxt_pend;  cont_ff <= nxt_cont;
         open_ff <= nxt_open;  sector_ff <= nxt_sector;  boot_done_ff <= nxt_boot_done;
         err_ff <= nxt_err;  ctrl_ff <= nxt_ctrl;  addr_ff <= nxt_addr;  wdata_ff <= nxt_wdata;
         prdata_ff <= nxt_prdata;  pready_ff <= nxt_pready;  pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata       = prdata_ff;
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign flash_sck    = sck_ff;
   assign flash_cs_n   = cs_n_ff;
   assign flash_io_out = io_out_ff;
   assign flash_io_oe  = io_oe_ff;

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_qread_needs_allow;
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr && (cmd_op == OP_QDDR_READ) && !four_line_cmd_mode && !qla) |=> (st_ff == ST_IDLE) && err_ff;
   endproperty
   a_qread_needs_allow: assert property (p_qread_needs_allow) else $error("quad read started without lane allow");

   property p_addr_four_lanes;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ST_ADDR && op_ff == OP_QDDR_READ && last) |-> (io_oe_ff == 4'hf) && !cs_n_ff;
   endproperty
   a_addr_four_lanes: assert property (p_addr_four_lanes) else $error("quad address not on four lanes");

   property p_cmd_lanes;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ST_CMD && last && !sck_ff) |-> (io_oe_ff == (four_line_cmd_mode ? 4'hf : 4'h1));
   endproperty
   a_cmd_lanes: assert property (p_cmd_lanes) else $error("opcode lane count wrong");

   property p_mode_nibble;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ST_MODE && last && !sck_ff) |-> (io_out_ff == (contreq ? MODE_CONT_NIB : 4'h0)) ##1 cont_ff == contreq;
   endproperty
   a_mode_nibble: assert property (p_mode_nibble) else $error("mode nibble wrong");

   property p_float_nibble;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ST_MODE && last && sck_ff && dmy == 4'h1) |-> (io_oe_ff == 4'h0);
   endproperty
   a_float_nibble: assert property (p_float_nibble) else $error("don't-care nibble driven");

   property p_one_sector;
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr && cmd_op == OP_SEC_OPEN && open_ff && addr_ff[ADDR_BITS-1:SECTOR_LSB] != sector_ff)
      |=> (st_ff == ST_IDLE) ##1 (st_ff == ST_IDLE);
   endproperty
   a_one_sector: assert property (p_one_sector) else $error("second sector opened");

   property p_boot_no_cmd;
      @(posedge pclk) disable iff (!presetn)
      (st_ff != ST_IDLE && op_ff == OP_BOOT_STREAM) |-> (io_oe_ff == 4'h0) && (st_ff != ST_CMD);
   endproperty
   a_boot_no_cmd: assert property (p_boot_no_cmd) else $error("host drove lines during boot stream");

   property p_boot_once;
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr && cmd_op == OP_BOOT_STREAM && boot_done_ff) |=> (st_ff == ST_IDLE) && $stable(cs_n_ff);
   endproperty
   a_boot_once: assert property (p_boot_once) else $error("boot stream restarted");

   property p_write_allow_cmd_first;
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr && !refuse && cmd_op == OP_WORD_WR) |=> (st_ff == ST_CMD) && (tx_ff[31:24] == OPC_WRITE_ALLOW);
   endproperty
   a_write_allow_cmd_first: assert property (p_write_allow_cmd_first) else $error("boot word write without write allow");

   property p_cs_after_32;
      @(posedge pclk) disable iff (!presetn)
      (st_ff == ST_WDATA && fin) |=> cs_n_ff && (st_ff == ST_GAP) && !sck_ff;
   endproperty
   a_cs_after_32: assert property (p_cs_after_32) else $error("select not raised after last bit");

endmodule
`default_nettype wire

// ---- qdb_flash_model.sv ----
// qdb_flash_model: behavioural flash that handles only the boot word commands.
// assumes: mode 0 link driven by the host, single-line frames.
`timescale 1ns/10ps
`default_nettype none
module qdb_flash_model
   import qdb_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic [3:0] io_in,
   output logic      [3:0] io_out
);
   logic [7:0]  op = 0;
   logic [31:0] word = 0, sh = 0;
   int          n = 0;
   logic        write_latch_flag = 0, drv = 0, bitv = 0, tog = 0;
   // released lines flip every pclk so a stale value is never read
   always @(posedge pclk) tog <= ~tog;
   assign io_out = {tog, tog, drv ? bitv : tog, tog};
   always @(negedge cs_n) begin
      n = 0;
      drv = 0;
   end
   always @(posedge sck) if (!cs_n) begin
      if (n < 8) op = {op[6:0], io_in[0]};
      else sh = {sh[30:0], io_in[0]};
      n = n + 1;
   end
   always @(negedge sck) if (!cs_n && op == OPC_BOOT_RD && n >= 8) begin
      drv = 1;
      bitv = word[31 - (n - 8) % 32];
   end
   always @(posedge cs_n) begin
      drv = 0;
      if (op == OPC_WRITE_ALLOW && n == 8) write_latch_flag = 1;
      if (op == OPC_BOOT_WR && n == 40 && write_latch_flag) begin
         word = sh;
         write_latch_flag = 0;
      end
   end
endmodule
`default_nettype wire

// ---- quad_dtr_read_boot_stream_ctl_tb.sv ----
// quad_dtr_read_boot_stream_ctl_tb: random and corner tests of the flash host.
// assumes: qdb_pkg compiled first; the model answers boot word commands.
`timescale 1ns/10ps
`default_nettype none
module quad_dtr_read_boot_stream_ctl_tb
   import qdb_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, anyoe;
   logic [7:0]  paddr = 0, opc;
   logic [31:0] pwdata = 0, prdata, rd, wd, sa, seed = 32'h2;
   logic        flash_sck, flash_cs_n;
   logic [3:0]  flash_io_in, flash_io_out, flash_io_oe, dev_io;
   int          err_count = 0, n_tests = 0, clk_n = 0, frames = 0, fr = 0, cyc = 0;
   int          tc[3] = '{2, 1, 4}, tn[3] = '{8, 32, 40}, qn[4], qs[4] = '{0, 1, 0, 0};
   logic [7:0]  to[3] = '{OPC_SECTOR_CLOSE, OPC_SECTOR_OPEN, OPC_BOOT_RD};
   logic [31:0] qc[4] = '{32'h632, 32'h636, 32'h632, 32'h631};
   always #5 pclk = ~pclk;
   assign flash_io_in = (flash_io_oe & flash_io_out) | (~flash_io_oe & dev_io);
   qdb_host #(.SCK_HALF(4)) uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .flash_sck, .flash_cs_n, .flash_io_in, .flash_io_out, .flash_io_oe);
   qdb_flash_model dev (.pclk, .sck(flash_sck), .cs_n(flash_cs_n), .io_in(flash_io_out), .io_out(dev_io));
   // ****************************************************************
   // link monitor, checks and bus tasks
   // ****************************************************************
   always @(negedge flash_cs_n) begin
      clk_n = 0;
      frames++;
      anyoe = 0;
   end
   always @(posedge flash_sck) if (!flash_cs_n) begin
      if (clk_n < 8) opc = {opc[6:0], flash_io_out[0]};
      clk_n++;
      anyoe |= |flash_io_oe;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         give_verdict;
      end
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function int clks(int four_line_cmd_mode, int cont);
      return (cont ? 0 : (four_line_cmd_mode ? 2 : 8)) + 3 + 6 + 4;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic op(input int c);
      apb(1, REG_CMD, 32'(c));
      repeat (600) begin
         apb(0, REG_STATUS, 0);
         if (rd[ST_BUSY_BIT] === 1'b0) break;
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      qn = '{clks(0, 0), clks(0, 0), clks(0, 1), clks(1, 0)};
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, REG_CTRL, 0); chk(rd, CTRL_RESET, "ctrl reset");
      apb(0, 8'h20, 0); chk(e, 1, "unmapped err");
      apb(0, REG_CMD, 0); chk(rd, 0, "cmd read");
      apb(1, REG_CTRL, 32'h5630); op(3); $display("test boot done");
      chk(clk_n, 37, "boot clocks");
      chk(anyoe, 0, "boot no command");
      chk(rd[ST_BOOTDONE_BIT], 1, "boot done");
      apb(1, REG_CTRL, 32'h632);
      sa = rnd() & 32'hff_ffff;
      for (int i = 0; i < 3; i++) begin
         apb(1, REG_ADDR, sa); op(tc[i]);
         chk(opc, to[i], "opcode");
         chk(clk_n, tn[i], "frame clocks");
      end
      wd = rnd(); apb(1, REG_WDATA, wd); fr = frames; op(5);
      chk(frames - fr, 2, "write frames");
      chk(opc, OPC_BOOT_WR, "write opcode");
      chk(clk_n, 40, "write clocks");
      op(4); apb(0, REG_RDATA, 0); chk(rd, wd, "word round trip"); $display("test word done");
      for (int m = 0; m < 4; m++) begin
         apb(1, REG_CTRL, qc[m]); op(0);
         if (m == 0) chk(opc, OPC_QDDR_READ, "read opcode");
         chk(clk_n, qn[m], "read clocks");
         chk(rd[ST_CONT_BIT], qs[m], "continuous");
      end
      apb(1, REG_CTRL, 32'h630); fr = frames; op(0);
      chk(rd[ST_ERR_BIT], 1, "read no quad");
      apb(1, REG_STATUS, 2); apb(1, REG_ADDR, sa ^ 32'h1000); op(1);
      chk(rd[ST_ERR_BIT], 1, "second sector");
      apb(1, REG_STATUS, 2); op(3);
      chk(rd[ST_ERR_BIT], 1, "second boot");
      chk(frames, fr, "refused frames");
      $display("test refusals done");
      give_verdict;
   end
endmodule
`default_nettype wire
